// ===== core/wpc_pkg.sv
package wpc_pkg;
  // ---------------------------------------------------------------
  // Register map, as word index; byte address is four times the index
  // ---------------------------------------------------------------
  localparam int             ADDR_W      = 12;
  localparam logic [8:0]     IDX_AMP_CFG = 9'h033;
  localparam logic [8:0]     IDX_AMP_REF = 9'h034;
  localparam logic [8:0]     IDX_AMP_AVG = 9'h035;
  localparam logic [8:0]     IDX_AMP_RES = 9'h036;
  localparam logic [8:0]     IDX_PH_CFG  = 9'h037;
  localparam logic [8:0]     IDX_PH_REF  = 9'h038;
  localparam logic [8:0]     IDX_PH_AVG  = 9'h039;
  localparam logic [8:0]     IDX_PH_RES  = 9'h03a;
  localparam logic [8:0]     IDX_FLAGS   = 9'h040;
  // Secondary space sits above the primary one, index bit 8 set
  localparam logic [8:0]     IDX_RC_CAL  = 9'h139;
  // ---------------------------------------------------------------
  // Fields of the configuration registers
  // ---------------------------------------------------------------
  localparam int             DELTA_LSB   = 4;
  localparam int             INCL_BIT    = 3;
  localparam int             WEIGHT_LSB  = 1;
  localparam int             REFSEL_BIT  = 0;
  localparam logic [2:0]     WEIGHT_BASE = 3'h2;
  localparam logic [7:0]     REG_RST     = 8'h00;
  localparam logic [1:0]     RESP_OKAY   = 2'h0;
  localparam logic [1:0]     RESP_DECERR = 2'h3;
  localparam int             CH_PHASE    = 0;
  localparam int             CH_AMP      = 1;
  localparam int             NUM_CH      = 2;

  typedef struct packed {
    logic [NUM_CH-1:0][7:0] cfg;
    logic [NUM_CH-1:0][7:0] refv;
    logic [NUM_CH-1:0][7:0] avg;
    logic [NUM_CH-1:0][7:0] res;
    logic [NUM_CH-1:0]      flag;
    logic                   aw_got;
    logic [8:0]             aw_idx;
    logic                   w_got;
    logic [7:0]             w_byte;
    logic                   w_lane0;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
  } wpc_state_t;
endpackage : wpc_pkg

// ===== core/wpc_top.sv
// Functional notes
// - Phase deviation over delta raises phase wakeup
// - Include-trigger bit decides averaging of trigger result
// - Weight code 00..11 gives 4,8,16,32
// - Phase reference select: register or average
// - Phase average readable at 39h
// - Latest phase result readable at 3Ah
// - Amplitude average readable at 35h
// - Latest amplitude result readable at 36h
// - Three-bit RC trim code readout, upper zero
// - Amplitude uses same delta, include, weight scheme
// - Amplitude reference register at 34h when unselected
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module wpc_top
  import wpc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic              phase_meas_valid,
  input  wire logic [7:0]        phase_meas_data,
  input  wire logic              amp_meas_valid,
  input  wire logic [7:0]        amp_meas_data,
  input  wire logic [2:0]        rc_trim_code,
  output logic                   phase_wakeup,
  output logic                   amplitude_wakeup,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  // Measurement inputs come from front-end logic on clk, so no sync.
  wpc_state_t s;
  wpc_state_t next_s;
  logic [NUM_CH-1:0]      mvalid;
  logic [NUM_CH-1:0][7:0] mdata;
  logic [NUM_CH-1:0]      trig;
  logic [NUM_CH-1:0][7:0] next_avg_calc;
  logic                   have_aw;
  logic                   have_w;
  logic [8:0]             wr_idx;
  logic [7:0]             wr_byte;
  logic                   wr_lane0;
  logic [8:0]             rd_idx;
  logic [7:0]             rd_val;
  logic                   rd_hit;

  assign mvalid = {amp_meas_valid, phase_meas_valid};
  assign mdata  = {amp_meas_data, phase_meas_data};

  // ---------------------------------------------------------------
  // Compare and average
  // ---------------------------------------------------------------
  always_comb begin
    logic [7:0]        refsel;
    logic signed [8:0] dref;
    logic [7:0]        adiff;
    logic signed [8:0] davg;
    logic signed [8:0] step;
    logic [2:0]        shamt;
    refsel        = '0;
    dref          = '0;
    adiff         = '0;
    davg          = '0;
    step          = '0;
    shamt         = '0;
    trig          = '0;
    next_avg_calc = s.avg;
    for (int c = 0; c < NUM_CH; c++) begin
      refsel = s.cfg[c][REFSEL_BIT] ? s.avg[c] : s.refv[c];
      dref   = $signed({1'b0, mdata[c]}) - $signed({1'b0, refsel});
      adiff  = dref[8] ? 8'((-dref)) : dref[7:0];
      trig[c] = mvalid[c] && (adiff > {4'h0, s.cfg[c][DELTA_LSB +: 4]});
      shamt  = WEIGHT_BASE + {1'b0, s.cfg[c][WEIGHT_LSB +: 2]};
      davg   = $signed({1'b0, mdata[c]}) - $signed({1'b0, s.avg[c]});
      step   = davg >>> shamt;
      if (mvalid[c] && !(trig[c] && !s.cfg[c][INCL_BIT])) begin
        next_avg_calc[c] = s.avg[c] + step[7:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------
  // Only byte lane 0 holds register bits; other lanes are ignored.
  assign s_axi_awready = !s.aw_got && !s.bvalid;
  assign s_axi_wready  = !s.w_got && !s.bvalid;
  assign s_axi_arready = !s.rvalid;
  assign have_aw  = s.aw_got || (s_axi_awvalid && s_axi_awready);
  assign have_w   = s.w_got || (s_axi_wvalid && s_axi_wready);
  assign wr_idx   = s.aw_got ? s.aw_idx : s_axi_awaddr[10:2];
  assign wr_byte  = s.w_got ? s.w_byte : s_axi_wdata[7:0];
  assign wr_lane0 = s.w_got ? s.w_lane0 : s_axi_wstrb[0];
  assign rd_idx   = s_axi_araddr[10:2];

  always_comb begin
    rd_hit = 1'b1;
    case (rd_idx)
      IDX_AMP_CFG: rd_val = s.cfg[CH_AMP];
      IDX_AMP_REF: rd_val = s.refv[CH_AMP];
      IDX_AMP_AVG: rd_val = s.avg[CH_AMP];
      IDX_AMP_RES: rd_val = s.res[CH_AMP];
      IDX_PH_CFG:  rd_val = s.cfg[CH_PHASE];
      IDX_PH_REF:  rd_val = s.refv[CH_PHASE];
      IDX_PH_AVG:  rd_val = s.avg[CH_PHASE];
      IDX_PH_RES:  rd_val = s.res[CH_PHASE];
      IDX_FLAGS:   rd_val = {6'h00, s.flag};
      IDX_RC_CAL:  rd_val = {5'h00, rc_trim_code};
      default: begin
        rd_val = REG_RST;
        rd_hit = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic             commit;
    logic             hit;
    logic [NUM_CH-1:0] clr;
    next_s = s;
    commit = have_aw && have_w && !s.bvalid;
    hit    = 1'b0;
    clr    = '0;
    next_s.avg = next_avg_calc;
    for (int c = 0; c < NUM_CH; c++) begin
      if (mvalid[c]) begin
        next_s.res[c] = mdata[c];
      end
    end
    if (commit) begin
      case (wr_idx)
        IDX_AMP_CFG, IDX_AMP_REF, IDX_PH_CFG, IDX_PH_REF, IDX_FLAGS: hit = 1'b1;
        IDX_AMP_AVG, IDX_AMP_RES, IDX_PH_AVG, IDX_PH_RES, IDX_RC_CAL: hit = 1'b1;
        default: hit = 1'b0;
      endcase
      if (wr_lane0) begin
        case (wr_idx)
          IDX_AMP_CFG: next_s.cfg[CH_AMP]    = wr_byte;
          IDX_AMP_REF: next_s.refv[CH_AMP]   = wr_byte;
          IDX_PH_CFG:  next_s.cfg[CH_PHASE]  = wr_byte;
          IDX_PH_REF:  next_s.refv[CH_PHASE] = wr_byte;
          IDX_FLAGS:   clr = wr_byte[NUM_CH-1:0];
          default: clr = '0;
        endcase
      end
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = hit ? RESP_OKAY : RESP_DECERR;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        next_s.aw_got = 1'b1;
        next_s.aw_idx = s_axi_awaddr[10:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        next_s.w_got   = 1'b1;
        next_s.w_byte  = s_axi_wdata[7:0];
        next_s.w_lane0 = s_axi_wstrb[0];
      end
    end
    // A new trigger wins over a clear in the same cycle
    next_s.flag = (s.flag & ~clr) | trig;
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_s.rvalid = 1'b1;
      next_s.rdata  = {24'h000000, rd_val};
      next_s.rresp  = rd_hit ? RESP_OKAY : RESP_DECERR;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign phase_wakeup     = s.flag[CH_PHASE];
  assign amplitude_wakeup = s.flag[CH_AMP];
  assign s_axi_bvalid     = s.bvalid;
  assign s_axi_bresp      = s.bresp;
  assign s_axi_rvalid     = s.rvalid;
  assign s_axi_rdata      = s.rdata;
  assign s_axi_rresp      = s.rresp;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence ar_take_s(logic [8:0] idx);
    s_axi_arvalid && s_axi_arready && rd_idx == idx;
  endsequence

  sequence no_clear_s;
    !(have_aw && have_w && !s.bvalid && wr_idx == IDX_FLAGS && wr_lane0);
  endsequence

  sequence clr_wr_s(int ch);
    have_aw && have_w && !s.bvalid && wr_idx == IDX_FLAGS && wr_lane0 && wr_byte[ch];
  endsequence

  phase_trig_set_a: assert property (
    trig[CH_PHASE] |=> phase_wakeup)
    else $error("phase trigger did not set wakeup");
  amp_trig_set_a: assert property (
    amp_meas_valid && s.cfg[CH_AMP][REFSEL_BIT] == 1'b0
    && amp_meas_data > s.refv[CH_AMP] + {4'h0, s.cfg[CH_AMP][DELTA_LSB +: 4]}
    && s.refv[CH_AMP] < 8'h70 |=> amplitude_wakeup)
    else $error("amplitude over delta did not set wakeup");
  excl_avg_hold_a: assert property (
    trig[CH_PHASE] && !s.cfg[CH_PHASE][INCL_BIT] |=> $stable(s.avg[CH_PHASE]))
    else $error("excluded trigger changed phase average");
  weight_four_a: assert property (
    phase_meas_valid && !trig[CH_PHASE] && s.cfg[CH_PHASE][WEIGHT_LSB +: 2] == 2'h0
    && s.avg[CH_PHASE] < 8'hf0 && phase_meas_data == s.avg[CH_PHASE] + 8'h04
    |=> s.avg[CH_PHASE] == $past(s.avg[CH_PHASE]) + 8'h01)
    else $error("weight 4 step wrong");
  avg_toward_a: assert property (
    amp_meas_valid && amp_meas_data >= s.avg[CH_AMP]
    |=> s.avg[CH_AMP] >= $past(s.avg[CH_AMP]) && s.avg[CH_AMP] <= $past(amp_meas_data))
    else $error("average overshot result");
  ref_avg_quiet_a: assert property (
    !phase_wakeup && s.cfg[CH_PHASE][REFSEL_BIT] && phase_meas_valid
    && phase_meas_data == s.avg[CH_PHASE] |=> !phase_wakeup)
    else $error("equal to average yet phase wakeup");
  amp_ref_quiet_a: assert property (
    !amplitude_wakeup && !s.cfg[CH_AMP][REFSEL_BIT] && amp_meas_valid
    && amp_meas_data == s.refv[CH_AMP] |=> !amplitude_wakeup)
    else $error("equal to reference yet amplitude wakeup");
  ph_avg_read_a: assert property (
    ar_take_s(IDX_PH_AVG) |=> s_axi_rvalid && s_axi_rdata == {24'h000000, $past(s.avg[CH_PHASE])})
    else $error("phase average readback wrong");
  ph_res_read_a: assert property (
    ar_take_s(IDX_PH_RES) |=> s_axi_rdata == {24'h000000, $past(s.res[CH_PHASE])})
    else $error("phase result readback wrong");
  amp_avg_read_a: assert property (
    ar_take_s(IDX_AMP_AVG) |=> s_axi_rdata == {24'h000000, $past(s.avg[CH_AMP])})
    else $error("amplitude average readback wrong");
  amp_res_read_a: assert property (
    amp_meas_valid ##1 ar_take_s(IDX_AMP_RES) |=> s_axi_rdata[7:0] == $past(amp_meas_data, 2))
    else $error("amplitude result readback wrong");
  rc_read_a: assert property (
    ar_take_s(IDX_RC_CAL) |=> s_axi_rdata == {29'h0, $past(rc_trim_code)})
    else $error("rc trim readback wrong");
  flag_sticky_a: assert property (
    phase_wakeup and no_clear_s |=> phase_wakeup)
    else $error("phase wakeup dropped without clear");
  // Clears only win when no new trigger lands in the same cycle
  ph_flag_clear_a: assert property (
    clr_wr_s(CH_PHASE) and !trig[CH_PHASE] |=> !phase_wakeup)
    else $error("phase wakeup not cleared");
  amp_flag_clear_a: assert property (
    clr_wr_s(CH_AMP) and !trig[CH_AMP] |=> !amplitude_wakeup)
    else $error("amplitude wakeup not cleared");
  trig_wins_a: assert property (
    clr_wr_s(CH_PHASE) and trig[CH_PHASE] |=> phase_wakeup)
    else $error("clear beat a phase trigger");
  amp_excl_hold_a: assert property (
    trig[CH_AMP] && !s.cfg[CH_AMP][INCL_BIT] |=> $stable(s.avg[CH_AMP]))
    else $error("excluded trigger changed amplitude average");
  ph_res_take_a: assert property (
    phase_meas_valid |=> s.res[CH_PHASE] == $past(phase_meas_data))
    else $error("phase result not captured");
  amp_res_take_a: assert property (
    amp_meas_valid |=> s.res[CH_AMP] == $past(amp_meas_data))
    else $error("amplitude result not captured");
  // Answers stand until taken; a slow master would otherwise lose them
  bresp_stand_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped before taken");
  rdata_stand_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped before taken");
endmodule : wpc_top
`default_nettype wire

// ===== test/tb_wpc_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_wpc_top;
  import wpc_pkg::*;
  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] refv;
    logic [7:0] d;
    logic [7:0] avg;
    logic       flag;
  } wpc_tb_row_t;
  logic              clk, srst, phase_meas_valid, amp_meas_valid;
  logic [7:0]        phase_meas_data, amp_meas_data;
  logic [2:0]        rc_trim_code;
  logic              phase_wakeup, amplitude_wakeup;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0]       s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]        s_axi_wstrb, wst;
  logic [1:0]        s_axi_bresp, s_axi_rresp, rsp;
  logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic              s_axi_rvalid, s_axi_rready;
  int                n_mismatch, comparisons;
  logic [8:0]        i_cfg [2] = '{IDX_PH_CFG, IDX_AMP_CFG};
  // Rows run in order: each average builds on the one before
  wpc_tb_row_t       rows [7] = '{
    '{8'h48, 8'h0a, 8'h0e, 8'h03, 1'b0},
    '{8'h48, 8'h0a, 8'h0f, 8'h06, 1'b1},
    '{8'h40, 8'h0a, 8'h64, 8'h06, 1'b1},
    '{8'h47, 8'h0a, 8'h02, 8'h05, 1'b0},
    '{8'h0b, 8'h0a, 8'h1e, 8'h08, 1'b1},
    '{8'hfc, 8'hc8, 8'hb9, 8'h13, 1'b0},
    '{8'hfc, 8'hc8, 8'hd8, 8'h1f, 1'b1}};

  wpc_top dut (.clk, .srst, .phase_meas_valid, .phase_meas_data, .amp_meas_valid,
    .amp_meas_data, .rc_trim_code, .phase_wakeup, .amplitude_wakeup, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // Bus and strobe tasks
  // ---------------------------------------------------------------
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      n_mismatch++;
    end
  endtask : chk

  // Readies are sampled mid-cycle so the handshake edge is known without a race
  task automatic axi_wr(input logic [8:0] idx, input logic [7:0] d, output logic [1:0] resp);
    int   n;
    logic ta, tw, got;
    @(posedge clk);
    s_axi_awaddr  <= {1'b0, idx, 2'b00};
    s_axi_wdata   <= {24'h000000, d};
    s_axi_wstrb   <= wst;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge clk);
      ta   = s_axi_awvalid && s_axi_awready;
      tw   = s_axi_wvalid && s_axi_wready;
      got  = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (got) begin
        s_axi_bready <= 1'b0;
        break;
      end
    end
    if (n == 40) begin
      chk("write answer", 32'h1, 32'h0);
      end_sim();
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [8:0] idx, output logic [31:0] d, output logic [1:0] resp);
    int   n;
    logic ta, got;
    @(posedge clk);
    s_axi_araddr  <= {1'b0, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge clk);
      ta   = s_axi_arvalid && s_axi_arready;
      got  = s_axi_rvalid;
      d    = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge clk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (got) begin
        s_axi_rready <= 1'b0;
        break;
      end
    end
    if (n == 40) begin
      chk("read answer", 32'h1, 32'h0);
      end_sim();
    end
  endtask : axi_rd

  task automatic meas(input int ch, input logic [7:0] d);
    @(posedge clk);
    phase_meas_valid <= (ch == 0);
    amp_meas_valid   <= (ch == 1);
    phase_meas_data  <= d;
    amp_meas_data    <= d;
    @(posedge clk);
    phase_meas_valid <= 1'b0;
    amp_meas_valid   <= 1'b0;
    @(negedge clk);
  endtask : meas

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {phase_meas_valid, amp_meas_valid, phase_meas_data, amp_meas_data} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, rc_trim_code} = '0;
    s_axi_wstrb = 4'h1;
    wst         = 4'h1;
    srst        = 1'b1;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    for (int ch = 0; ch < 2; ch++) begin
      for (int r = 0; r < 7; r++) begin
        axi_wr(i_cfg[ch], rows[r].cfg, rsp);
        chk("cfg bresp", {30'h0, RESP_OKAY}, {30'h0, rsp});
        axi_wr(i_cfg[ch] + 9'h001, rows[r].refv, rsp);
        axi_wr(IDX_FLAGS, 8'h03, rsp);
        meas(ch, rows[r].d);
        chk("wakeup", {31'h0, rows[r].flag}, {31'h0, ch != 0 ? amplitude_wakeup : phase_wakeup});
        axi_rd(i_cfg[ch] + 9'h003, rd, rsp);
        chk("result", {24'h0, rows[r].d}, rd);
        axi_rd(i_cfg[ch] + 9'h002, rd, rsp);
        chk("average", {24'h0, rows[r].avg}, rd);
      end
    end
    $display("done: averaging rows");
    // Average as reference puts 200 far off, so the phase flag must set
    axi_wr(IDX_PH_CFG, 8'hfd, rsp);
    meas(0, 8'hc8);
    chk("phase flag held", 32'h1, {31'h0, phase_wakeup});
    axi_wr(IDX_FLAGS, 8'h01, rsp);
    chk("phase flag cleared", 32'h0, {31'h0, phase_wakeup});
    chk("amp flag kept", 32'h1, {31'h0, amplitude_wakeup});
    $display("done: sticky flags");
    axi_wr(IDX_PH_RES, 8'h55, rsp);
    chk("ro bresp", {30'h0, RESP_OKAY}, {30'h0, rsp});
    axi_rd(IDX_PH_RES, rd, rsp);
    chk("ro result", 32'h000000c8, rd);
    wst = 4'h0;
    axi_wr(IDX_PH_REF, 8'h99, rsp);
    wst = 4'h1;
    axi_rd(IDX_PH_REF, rd, rsp);
    chk("strobe off ref", 32'h000000c8, rd);
    axi_wr(9'h03f, 8'h11, rsp);
    chk("unmapped bresp", {30'h0, RESP_DECERR}, {30'h0, rsp});
    axi_rd(9'h03f, rd, rsp);
    chk("unmapped rresp", {30'h0, RESP_DECERR}, {30'h0, rsp});
    chk("unmapped rdata", 32'h0, rd);
    $display("done: bus corner cases");
    for (int c = 0; c < 8; c++) begin
      @(posedge clk);
      rc_trim_code <= c[2:0];
      axi_rd(IDX_RC_CAL, rd, rsp);
      chk("rc trim", {29'h0, c[2:0]}, rd);
    end
    axi_rd(IDX_PH_AVG, rd, rsp);
    chk("phase avg apart", 32'h00000029, rd);
    axi_wr(IDX_PH_CFG, 8'hf0, rsp);
    axi_wr(IDX_PH_REF, 8'h2d, rsp);
    meas(0, 8'h2d);
    chk("weight 4 quiet", 32'h0, {31'h0, phase_wakeup});
    axi_rd(IDX_PH_AVG, rd, rsp);
    chk("weight 4 step", 32'h0000002a, rd);
    $display("done: trim readout");
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    for (logic [8:0] i = 9'h033; i <= 9'h03a; i++) begin
      axi_rd(i, rd, rsp);
      chk("reset value", 32'h0, rd);
    end
    chk("flags after reset", 32'h0, {30'h0, amplitude_wakeup, phase_wakeup});
    $display("done: mid-run reset");
    end_sim();
  end
endmodule : tb_wpc_top
`default_nettype wire
